//--- design/trig_ctl.sv
// Global status and control bank for twelve trigger output units
`timescale 1ns/10ps
`default_nettype none
module trig_ctl
    import trig_ctl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [DATA_W-1:0] host_wdata,
    output logic [DATA_W-1:0] host_rdata,
    input wire logic [NUM_UNITS-1:0] unit_fired,
    input wire logic [NUM_UNITS-1:0] target_late,
    input wire logic [NUM_UNITS-1:0] event_notify_select,
    input wire logic [NUM_UNITS-1:0] timing_output_irq_enable,
    output logic [NUM_UNITS-1:0] unit_run_en,
    output logic [NUM_UNITS-1:0] unit_soft_reset,
    output logic [NUM_UNITS-1:0] output_unit_error_status,
    output logic trigger_irq
);
    // ==========================================================
    // State registers
    logic [NUM_UNITS-1:0] enable_ff, nxt_enable;
    logic [NUM_UNITS-1:0] done_ff, nxt_done;
    logic [NUM_UNITS-1:0] err_ff, nxt_err;
    logic [NUM_UNITS-1:0] srst_ff, nxt_srst;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [NUM_UNITS-1:0] running;
    logic [NUM_UNITS-1:0] fire_ok;
    logic [NUM_UNITS-1:0] err_set;
    wire logic wr_done = host_wr && (host_addr == OFS_DONE);
    wire logic wr_en = host_wr && (host_addr == OFS_ENABLE);
    wire logic wr_srst = host_wr && (host_addr == OFS_SOFT_RST);
    wire logic [NUM_UNITS-1:0] wbits = host_wdata[NUM_UNITS-1:0];

    // ==========================================================
    // Per-unit next-state logic
    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++)
        begin : g_unit
            // RL8 RL12 fire gating
            assign fire_ok[g] = unit_fired[g] && enable_ff[g] && !srst_ff[g];
            // RL13 late target error
            assign err_set[g] = target_late[g] && event_notify_select[g] && enable_ff[g]
                && !srst_ff[g];
            // RL7 RL10 RL11 RL14 enable self clear
            assign nxt_enable[g] = (srst_ff[g] || err_set[g] || err_ff[g] || fire_ok[g]) ? 1'b0
                : (wr_en ? wbits[g] : enable_ff[g]);
            // RL13 error clear on enable write 0
            assign nxt_err[g] = srst_ff[g] ? 1'b0
                : (err_set[g] ? 1'b1 : ((wr_en && !wbits[g]) ? 1'b0 : err_ff[g]));
            // RL4 RL5 done set wins over clear
            assign nxt_done[g] = (fire_ok[g] && event_notify_select[g]) ? 1'b1
                : ((srst_ff[g] || (wr_done && wbits[g])) ? 1'b0 : done_ff[g]);
            // RL10 soft reset self clear after one cycle
            assign nxt_srst[g] = wr_srst && wbits[g];
            // RL1 RL2 RL14 running status
            assign running[g] = enable_ff[g] && !err_ff[g] && !srst_ff[g];
        end
    endgenerate

    // ==========================================================
    // Read data selection
    // RL3 reserved bits read zero
    always_comb
    begin
        case (host_addr)
            OFS_RUNNING: nxt_rdata = {RESERVED_BITS, running};
            OFS_DONE: nxt_rdata = {RESERVED_BITS, done_ff};
            OFS_ENABLE: nxt_rdata = {RESERVED_BITS, enable_ff};
            OFS_SOFT_RST: nxt_rdata = {RESERVED_BITS, srst_ff};
            default: nxt_rdata = '0;
        endcase
    end

    // Register update
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            enable_ff <= RST_UNITS;
            done_ff <= RST_UNITS;
            err_ff <= RST_UNITS;
            srst_ff <= RST_UNITS;
            rdata_ff <= '0;
        end
        else
        begin
            enable_ff <= nxt_enable;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
            srst_ff <= nxt_srst;
            rdata_ff <= host_rd ? nxt_rdata : rdata_ff;
        end
    end

    // ==========================================================
    // Outputs
    assign host_rdata = rdata_ff;
    assign unit_run_en = running;
    assign unit_soft_reset = srst_ff;
    assign output_unit_error_status = err_ff;
    // RL6 interrupt request
    assign trigger_irq = |(done_ff & timing_output_irq_enable);
endmodule // trig_ctl
`default_nettype wire

//--- design/trig_ctl_pkg.sv
// Package of constants for the trigger unit global control register bank
// Summary of operation
// RL1: Running bit reads 1 while the unit is enabled and error free.
// RL2: Running bit reads 0 once the unit has finished and gone idle.
// RL3: Twelve unit bits, bit 0 is unit 1; bits 15 to 12 read zero.
// RL4: Trigger event with notify selected sets the unit's event-done bit.
// RL5: Event-done clears on a host write of 1 or on a soft reset; a write of 0 leaves it.
// RL6: Interrupt request when event-done and the unit's irq enable are both set.
// RL7: Writing 1 to enable starts the unit; it self-clears when the output fires.
// RL8: With enable at 0 the unit stays disabled and gives no trigger.
// RL9: Host enables only the head unit of a cascade chain.
// RL10: Soft reset bit forces unit inactive and default; bit self-clears.
// RL11: Soft reset stops a running cascade and readies the unit again.
// RL12: With soft reset at 0 the unit runs normally.
// RL13: Error set on late target with notify; cleared by writing enable 0.
// RL14: Soft reset or error clears running in that cycle; enable clears with the error, or one cycle after soft reset.
package trig_ctl_pkg;
    // ==========================================================
    // Register map and layout
    localparam int NUM_UNITS = 12;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam logic [10:0] OFS_RUNNING = 11'h202;
    localparam logic [10:0] OFS_DONE = 11'h204;
    localparam logic [10:0] OFS_ENABLE = 11'h206;
    localparam logic [10:0] OFS_SOFT_RST = 11'h208;
    localparam logic [11:0] RST_UNITS = 12'h000;
    localparam logic [3:0] RESERVED_BITS = 4'h0;
endpackage

//--- verification/trig_ctl_assertions.sv
// Checker for the trigger unit control bank
`timescale 1ns/10ps
`default_nettype none
module trig_ctl_assertions import trig_ctl_pkg::*; (
    input wire logic clk_sys, reset, host_wr, host_rd, trigger_irq,
    input wire logic [10:0] host_addr,
    input wire logic [15:0] host_rdata,
    input wire logic [11:0] unit_fired, unit_run_en, timing_output_irq_enable,
    input wire logic [11:0] unit_soft_reset, output_unit_error_status);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_rsvd_zero: assert property (host_rdata[15:12] == 4'h0) else $error("rsvd");
    a_irq_mask: assert property (!timing_output_irq_enable |-> !trigger_irq)
        else $error("irq");
    a_fire_clear: assert property (unit_fired[0] && unit_run_en[0] && !host_wr
        |=> !unit_run_en[0]) else $error("fire");
    a_swrst_once: assert property (unit_soft_reset[0] && !host_wr
        |=> !unit_soft_reset[0]) else $error("swrst");
    a_swrst_stop: assert property (unit_soft_reset[0] |=> !unit_run_en[0])
        else $error("swrun");
    a_err_stop: assert property ($fell(output_unit_error_status[0]) |-> !unit_run_en[0])
        else $error("err");
    a_run_read: assert property (host_rd && host_addr == OFS_RUNNING
        |=> host_rdata[11:0] == $past(unit_run_en)) else $error("rd");
    a_read_hold: assert property (!host_rd |=> $stable(host_rdata)) else $error("hold");
endmodule // trig_ctl_assertions
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the trigger unit control bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import trig_ctl_pkg::*;
    logic clk_sys = 0, reset = 1, host_wr = 0, host_rd = 0, trigger_irq;
    logic [10:0] host_addr = '0;
    logic [15:0] host_wdata = '0, host_rdata;
    logic [11:0] unit_fired = '0, target_late = '0, event_notify_select = '0, v, n;
    logic [11:0] timing_output_irq_enable = '0, unit_run_en, unit_soft_reset;
    logic [11:0] output_unit_error_status;
    int bad_count = 0, checked = 0;
    trig_ctl uut (.*);
    always #5 clk_sys = ~clk_sys;
    // Expected read word: reserved bits always zero
    function automatic logic [15:0] w16(input logic [11:0] u); return {4'h0, u}; endfunction
    task automatic acc(input logic w, input logic [10:0] a, input logic [15:0] d);
        @(negedge clk_sys) {host_wr, host_rd, host_addr, host_wdata} = {w, !w, a, d};
        @(negedge clk_sys) {host_wr, host_rd} = 2'b00;
    endtask
    task automatic cmp(input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin bad_count++; $display("BAD %0t %h %h", $time, got, exp); end
    endtask
    task automatic rd(input logic [10:0] a, input logic [11:0] e);
        acc(0, a, '0); cmp(host_rdata, w16(e));
    endtask
    task automatic fire(input logic [11:0] f, l);
        @(negedge clk_sys) {unit_fired, target_late} = {f, l};
        @(negedge clk_sys) {unit_fired, target_late} = '0;
    endtask
    task automatic stop_test;
        $display("bad %0d checked %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin #100000; bad_count++; stop_test; end
    initial begin
        void'($urandom(32'hec86));
        repeat (4) @(negedge clk_sys);
        reset = 0;
        v = 12'($urandom) | 12'h001;
        n = 12'($urandom) | 12'h001;
        rd(OFS_DONE, '0);
        {event_notify_select, timing_output_irq_enable} = {n, n};
        acc(1, OFS_ENABLE, {4'hf, v});
        rd(OFS_RUNNING, v);
        fire(v, '0);
        rd(OFS_ENABLE, '0);
        rd(OFS_RUNNING, '0);
        rd(OFS_DONE, v & n);
        cmp({15'h0, trigger_irq}, 16'h0001);
        acc(1, OFS_DONE, '0);
        rd(OFS_DONE, v & n);
        acc(1, OFS_DONE, w16(v & n));
        rd(OFS_DONE, '0);
        fire('1, '0);
        rd(OFS_DONE, '0);
        rd(11'h20c, '0);
        acc(1, OFS_ENABLE, 16'h0fff);
        acc(1, OFS_SOFT_RST, w16(v));
        rd(OFS_RUNNING, ~v);
        acc(1, OFS_ENABLE, 16'h0001);
        fire('0, 12'h001);
        cmp(w16(output_unit_error_status), 16'h0001);
        acc(1, OFS_ENABLE, '0);
        cmp(w16(output_unit_error_status), '0);
        stop_test;
    end
endmodule // testbench
bind trig_ctl trig_ctl_assertions chk (.*);
`default_nettype wire
